//--- src/rosb_pkg.sv
// Package for the remap output selection bank: register map, field layout, carriers.
package rosb_pkg;

    // Register bus geometry
    localparam int ADDR_W = 4;
    localparam int DATA_W = 16;
    localparam int SEL_W = 5;

    // Register indices, one 16-bit register per pin pair
    localparam logic [ADDR_W-1:0] OUT_SELECT_PINS_6_7 = 4'h0;
    localparam logic [ADDR_W-1:0] OUT_SELECT_PINS_8_9 = 4'h1;
    localparam logic [ADDR_W-1:0] OUT_SELECT_PINS_10_11 = 4'h2;
    localparam logic [ADDR_W-1:0] OUT_SELECT_PINS_12_13 = 4'h3;
    localparam logic [ADDR_W-1:0] OUT_SELECT_PINS_14_15 = 4'h4;
    localparam logic [ADDR_W-1:0] OUT_SELECT_PINS_16_17 = 4'h5;
    localparam logic [ADDR_W-1:0] OUT_SELECT_PINS_18_19 = 4'h6;
    localparam logic [ADDR_W-1:0] OUT_SELECT_PINS_20_21 = 4'h7;
    localparam int NUM_REGS = 8;
    localparam int FIRST_PIN = 6;

    // Field positions inside each register
    localparam int ODD_LSB = 8;
    localparam int EVEN_LSB = 0;

    // Reset values
    localparam logic [SEL_W-1:0] SEL_RESET = 5'h00;
    localparam logic [DATA_W-1:0] RDATA_ZERO = 16'h0000;

    // Function number that leaves a pin to the port logic
    localparam logic [SEL_W-1:0] FUNC_NONE = 5'h00;

    // Register bus request carrier
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } rosb_req_t;

    // Pin driver carrier per pin
    typedef struct packed {
        logic periph_en;
        logic level;
    } rosb_pin_t;

endpackage

//--- src/rosb_pin_mux.sv
// One remappable pin: picks a peripheral output by function number.
`timescale 1ns/100ps
module rosb_pin_mux
    import rosb_pkg::*;
#(
    parameter int NUM_FUNCS = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [SEL_W-1:0] pin_function_select,
    input wire logic [NUM_FUNCS-1:0] periph_out,
    input wire logic port_out,
    output rosb_pin_t pin_drive
);

    // Elaboration check: the select field must reach every function
    if (NUM_FUNCS > (1 << SEL_W) || NUM_FUNCS < 2) begin : g_bad_funcs
        $error("rosb_pin_mux: NUM_FUNCS out of range");
    end

    // Function zero or beyond the table leaves the pin to the port
    wire logic func_valid;
    wire logic next_level;
    assign func_valid = (pin_function_select != FUNC_NONE) && (32'(pin_function_select) < NUM_FUNCS);
    assign next_level = func_valid ? periph_out[pin_function_select] : port_out;

    // Registered so pin drive is glitch free on a select change
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_drive <= '0;
        end else begin
            pin_drive.periph_en <= func_valid;
            pin_drive.level <= next_level;
        end
    end

endmodule

//--- src/rosb_bank.sv
// Remap output selection bank: eight selection registers and the pin muxes they steer.
`timescale 1ns/100ps
module rosb_bank
    import rosb_pkg::*;
#(
    parameter int NUM_FUNCS = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [DATA_W-1:0] reg_rdata,
    input wire logic [NUM_FUNCS-1:0] periph_out,
    input wire logic [2*NUM_REGS-1:0] port_out,
    output logic [2*NUM_REGS-1:0] remappable_pin,
    output logic [2*NUM_REGS-1:0] remappable_pin_periph_en
);

    ////////////////////////////////////////////////////////////////////////////
    // Bus request bundle

    rosb_req_t req;
    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

    // Address decode; indices above the bank are unmapped
    wire logic addr_hit;
    wire logic [2:0] reg_idx;
    assign addr_hit = (32'(req.addr) < NUM_REGS);
    assign reg_idx = req.addr[2:0];

    ////////////////////////////////////////////////////////////////////////////
    // Selection storage, one odd and one even field per register

    logic [SEL_W-1:0] sel_odd [NUM_REGS];
    logic [SEL_W-1:0] sel_even [NUM_REGS];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
            wire logic wr_hit;
            assign wr_hit = req.wr && addr_hit && (reg_idx == 3'(gi));

            // Only field bits are stored, so unimplemented bits never hold a write
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    sel_odd[gi] <= SEL_RESET;
                    sel_even[gi] <= SEL_RESET;
                end else if (wr_hit) begin
                    sel_odd[gi] <= req.wdata[ODD_LSB +: SEL_W];
                    sel_even[gi] <= req.wdata[EVEN_LSB +: SEL_W];
                end
            end

            // Odd pin takes the upper field, even pin the lower
            rosb_pin_t even_drv;
            rosb_pin_t odd_drv;

            rosb_pin_mux #(
                .NUM_FUNCS(NUM_FUNCS)
            ) u_even (
                .clk(clk),
                .nrst(nrst),
                .pin_function_select(sel_even[gi]),
                .periph_out(periph_out),
                .port_out(port_out[2*gi]),
                .pin_drive(even_drv)
            );

            rosb_pin_mux #(
                .NUM_FUNCS(NUM_FUNCS)
            ) u_odd (
                .clk(clk),
                .nrst(nrst),
                .pin_function_select(sel_odd[gi]),
                .periph_out(periph_out),
                .port_out(port_out[2*gi+1]),
                .pin_drive(odd_drv)
            );

            assign remappable_pin[2*gi] = even_drv.level;
            assign remappable_pin[2*gi+1] = odd_drv.level;
            assign remappable_pin_periph_en[2*gi] = even_drv.periph_en;
            assign remappable_pin_periph_en[2*gi+1] = odd_drv.periph_en;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Read path: gaps between fields forced to zero

    wire logic [DATA_W-1:0] read_word;
    wire logic [DATA_W-1:0] next_rdata;
    assign read_word = {3'h0, sel_odd[reg_idx], 3'h0, sel_even[reg_idx]};
    assign next_rdata = (req.rd && addr_hit) ? read_word : RDATA_ZERO;

    // Data stands only in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (!nrst) begin
            reg_rdata <= RDATA_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

endmodule

//--- tb/rosb_far_model.sv
// Far-side stand-in: peripheral outputs and port latches.
`timescale 1ns/100ps
module rosb_far_model
    import rosb_pkg::*;
#(
    parameter int NUM_FUNCS = 32
) (
    output logic [NUM_FUNCS-1:0] periph_out,
    output logic [2*NUM_REGS-1:0] port_out
);
    // Mixed patterns, so a wrong pick changes the pin level
    assign periph_out = {NUM_FUNCS/16{16'hC5A3}};
    assign port_out = 16'h3C96;
endmodule

//--- tb/rosb_bank_asserts.sv
// Port checker for the remap output selection bank.
`timescale 1ns/100ps
module rosb_bank_asserts
    import rosb_pkg::*;
#(
    parameter int NUM_FUNCS = 32
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [DATA_W-1:0] reg_rdata,
    input wire logic [2*NUM_REGS-1:0] port_out,
    input wire logic [2*NUM_REGS-1:0] remappable_pin,
    input wire logic [2*NUM_REGS-1:0] remappable_pin_periph_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    ////////////////////////////////////////
    // Mapped write, then a read of the same place
    sequence wr_then_rd;
        (reg_wr && !reg_addr[3]) ##1 (reg_rd && reg_addr == $past(reg_addr));
    endsequence
    // Reset has no disable, it checks the reset itself
    a_reset_clear: assert property (disable iff (1'b0) !nrst |=>
        reg_rdata == 16'h0000 && remappable_pin_periph_en == 16'h0000) else $error("reset not clear");
    a_top_zero: assert property (reg_rdata[15:13] == 3'h0) else $error("bits 15-13 set");
    a_mid_zero: assert property (reg_rdata[7:5] == 3'h0) else $error("bits 7-5 set");
    a_odd_back: assert property (wr_then_rd |=>
        ((reg_rdata ^ $past(reg_wdata, 2)) & 16'h1F00) == 16'h0000) else $error("odd field lost");
    a_even_back: assert property (wr_then_rd |=>
        ((reg_rdata ^ $past(reg_wdata, 2)) & 16'h001F) == 16'h0000) else $error("even field lost");
    a_unmapped_zero: assert property (reg_rd && reg_addr[3] |=>
        reg_rdata == 16'h0000) else $error("unmapped read not zero");
    // First edge after release still shows reset pins
    a_port_follow: assert property ($past(nrst) |->
        ((remappable_pin ^ $past(port_out)) & ~remappable_pin_periph_en) == 16'h0000) else $error("port lost");
endmodule

//--- tb/rosb_bank_bench.sv
// Self-checking bench for the remap output selection bank.
`timescale 1ns/100ps
module rosb_bank_bench import rosb_pkg::*;;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    rosb_req_t rq = '0;
    logic [DATA_W-1:0] rdata;
    logic [31:0] pf;
    logic [15:0] po, pin, en;
    int n_fail = 0;
    int n_tests = 0;
    always #20 clk = ~clk;
    rosb_far_model u_far (.periph_out(pf), .port_out(po));
    rosb_bank u_dut (.clk(clk), .nrst(nrst), .reg_addr(rq.addr), .reg_wdata(rq.wdata), .reg_wr(rq.wr),
        .reg_rd(rq.rd), .reg_rdata(rdata), .periph_out(pf), .port_out(po), .remappable_pin(pin),
        .remappable_pin_periph_en(en));
    ////////////////////////////////////////
    // Compare and report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Strobe stays up so a read may follow with no gap
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        rq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        rq <= '{addr: a, wdata: rq.wdata, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        rq.rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic idle(input int n);
        repeat (n) begin
            @(posedge clk);
            rq.wr <= 1'b0;
        end
    endtask
    task automatic test_done;
        $display("tests=%0d fails=%0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////
    // Main sequence; index 8 is the unmapped case
    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        for (int i = 0; i < NUM_REGS; i++) rd(i[3:0], 16'h0000);
        for (int i = 0; i < 9; i++) begin
            wr(i[3:0], 16'hFFFF ^ (16'(i) * 16'h0202));
            rd(i[3:0], i < 8 ? 16'h1F1F ^ (16'(i) * 16'h0202) : 16'h0000);
        end
        // Every pair now picks function 31-2i on both pins, so both pins of a pair show the same level
        #1 chk(en, 16'hFFFF);
        chk(pin, 16'hCF03);
        for (int f = 0; f < 32; f++) begin
            wr(4'h0, 16'(((31 - f) << 8) | f));
            idle(3);
            #1 chk(16'({en[1:0], pin[1:0]}), 16'({f != 31, f != 0, f != 31 ? pf[31 - f] : po[1],
                f != 0 ? pf[f] : po[0]}));
        end
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1 chk(en, 16'h0000);
        rd(4'h0, 16'h0000);
        test_done();
    end
endmodule

bind rosb_bank rosb_bank_asserts #(.NUM_FUNCS(NUM_FUNCS)) u_chk (.clk, .nrst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .port_out, .remappable_pin, .remappable_pin_periph_en);
